// *** shared/gear_clutch_pkg.sv ***
// Operation
// - capture all settings except axis count entering virtual mode
// - resample clutch command, mode, addresses and speed each cycle
// - reload teeth only on current value change
// - operation cycle period follows axis count
// - output equals input pulses times gear ratio
// - tooth counts 1 to 65535, default 1
// - forward keeps output direction with input
// - reverse negates the scaled pulses
// - clutch passes or blocks command pulses
// - smoothing clutch shapes rate at switching
// - direct clutch switches output immediately
// - smoothing offers time constant, exponential, linear
// - engaged passes pulses, disengaged passes none
// - done clears at switch, sets inside range
package gear_clutch_pkg;
   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_TEETH   = 8'h04;
   localparam logic [7:0] REG_AXES    = 8'h08;
   localparam logic [7:0] REG_SLIP    = 8'h0c;
   localparam logic [7:0] REG_INPOS   = 8'h10;
   localparam logic [7:0] REG_ON_ADDR = 8'h14;
   localparam logic [7:0] REG_OFFADDR = 8'h18;
   localparam logic [7:0] REG_SPEED   = 8'h1c;
   localparam logic [7:0] REG_STATUS  = 8'h20;
   localparam logic [7:0] REG_POS     = 8'h24;
   // ************************************************
   // control fields
   // ************************************************
   localparam int CTRL_VIRT   = 0;
   localparam int CTRL_REV    = 1;
   localparam int CTRL_CMD    = 2;
   localparam int CTRL_SMOOTH = 3;
   localparam int CTRL_METH   = 4;
   localparam int CTRL_MODE   = 8;
   localparam int CTRL_W      = 11;
   localparam int TEETH_OUT   = 16;
   localparam logic [15:0] TEETH_RST = 16'h0001;
   localparam logic [5:0]  AXES_RST  = 6'h01;
   localparam logic [2:0]  MODE_MAX  = 3'h4;
   typedef enum logic [1:0] {
      METH_TC  = 2'b00,
      METH_EXP = 2'b01,
      METH_LIN = 2'b10
   } smooth_meth_e;
   typedef enum logic [2:0] {
      MODE_ONOFF = 3'b000,
      MODE_ADDR  = 3'b001
   } clutch_mode_e;
   localparam int EXP_SHIFT = 2;
   localparam int LIN_SHIFT = 4;
   // ************************************************
   // operation cycle timing
   // ************************************************
   localparam int CLK_NS   = 4;
   localparam int CYC_NS_1 = 880000;
   localparam int CYC_NS_2 = 1770000;
   localparam int CYC_NS_3 = 3550000;
   localparam int CYC_NS_4 = 7110000;
   localparam int CYC_CLKS_1 = CYC_NS_1 / CLK_NS;
   localparam int CYC_CLKS_2 = CYC_NS_2 / CLK_NS;
   localparam int CYC_CLKS_3 = CYC_NS_3 / CLK_NS;
   localparam int CYC_CLKS_4 = CYC_NS_4 / CLK_NS;
   localparam logic [5:0] AXES_A = 6'h05;
   localparam logic [5:0] AXES_B = 6'h0e;
   localparam logic [5:0] AXES_C = 6'h1c;
   localparam int CNT_W = 21;
endpackage

// *** rtl/gear_clutch_transmission.sv ***
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module gear_clutch_transmission
   import gear_clutch_pkg::*;
#(
   parameter int IN_W  = 16,
   parameter int CYC_1 = CYC_CLKS_1,
   parameter int CYC_2 = CYC_CLKS_2,
   parameter int CYC_3 = CYC_CLKS_3,
   parameter int CYC_4 = CYC_CLKS_4
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   input  wire logic [7:0]             addr,
   input  wire logic [31:0]            wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [31:0]            rdata,
   input  wire logic signed [IN_W-1:0] in_travel,
   input  wire logic                   cv_change,
   output logic                        op_tick,
   output logic signed [31:0]          out_travel,
   output logic                        virt_active,
   output logic                        clutch_engaged,
   output logic                        smooth_done
);
   // ************************************************
   // elaboration checks
   // ************************************************
   if (IN_W < 2 || IN_W > 16) begin : g_bad_w
      $error("IN_W must be 2 to 16");
   end
   if (CYC_1 < 2 || CYC_4 >= (1 << CNT_W)) begin : g_bad_cyc
      $error("cycle counts out of range");
   end

   typedef struct packed {
      logic [CTRL_W-1:0] cfg_ctrl;
      logic [15:0]       cfg_in_t;
      logic [15:0]       cfg_out_t;
      logic [5:0]        cfg_axes;
      logic [31:0]       cfg_slip;
      logic [31:0]       cfg_inpos;
      logic [31:0]       cfg_on;
      logic [31:0]       cfg_off;
      logic [15:0]       cfg_speed;
      logic              virt;
      logic              act_cmd;
      logic [2:0]        act_mode;
      logic              mode_err;
      logic [31:0]       act_on;
      logic [31:0]       act_off;
      logic [15:0]       act_speed;
      logic [15:0]       act_in_t;
      logic [15:0]       act_out_t;
      logic              act_rev;
      logic              act_smooth;
      logic [1:0]        act_meth;
      logic [31:0]       act_slip;
      logic [31:0]       act_inpos;
      logic [CNT_W-1:0]  tick_cnt;
      logic              tick;
      logic              engaged;
      logic signed [16:0] rem;
      logic signed [31:0] g;
      logic signed [31:0] rate;
      logic signed [31:0] pos;
      logic              done;
      logic [31:0]       rdata;
   } state_s;

   state_s st;
   state_s next_st;

   logic [CNT_W-1:0]   lim;
   logic signed [33:0] acc;
   logic signed [33:0] quo;
   logic signed [33:0] rem_full;
   logic signed [31:0] g_new;
   logic signed [31:0] target;
   logic signed [31:0] diff;
   logic signed [31:0] step;
   logic signed [31:0] lin_max;
   logic signed [31:0] rate_new;
   logic [31:0]        left;
   logic               eng_new;
   logic [2:0]         mode_new;

   // ************************************************
   // operation cycle length from axis count
   // ************************************************
   always_comb begin
      if (st.cfg_axes <= AXES_A) begin
         lim = CNT_W'(CYC_1 - 1);
      end else if (st.cfg_axes <= AXES_B) begin
         lim = CNT_W'(CYC_2 - 1);
      end else if (st.cfg_axes <= AXES_C) begin
         lim = CNT_W'(CYC_3 - 1);
      end else begin
         lim = CNT_W'(CYC_4 - 1);
      end
   end

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      next_st.rdata = '0;
      // remainder carried so fractional pulses are never dropped
      acc = 34'(st.rem) + 34'(in_travel) * $signed({18'h0, st.act_out_t});
      quo = acc / $signed({18'h0, st.act_in_t});
      rem_full = acc - quo * $signed({18'h0, st.act_in_t});
      g_new = st.act_rev ? -quo[31:0] : quo[31:0];
      mode_new = st.cfg_ctrl[CTRL_MODE +: 3];
      eng_new = st.engaged;
      target = '0;
      diff = '0;
      step = '0;
      lin_max = '0;
      rate_new = '0;
      left = '0;

      if (wr) begin
         case (addr)
            REG_CTRL: begin
               next_st.cfg_ctrl = wdata[CTRL_W-1:0];
            end
            REG_TEETH: begin
               // zero is outside the legal tooth range and is ignored
               if (wdata[15:0] != '0) begin
                  next_st.cfg_in_t = wdata[15:0];
               end
               if (wdata[TEETH_OUT +: 16] != '0) begin
                  next_st.cfg_out_t = wdata[TEETH_OUT +: 16];
               end
            end
            REG_AXES: begin
               next_st.cfg_axes = wdata[5:0];
            end
            REG_SLIP: begin
               next_st.cfg_slip = wdata;
            end
            REG_INPOS: begin
               next_st.cfg_inpos = wdata;
            end
            REG_ON_ADDR: begin
               next_st.cfg_on = wdata;
            end
            REG_OFFADDR: begin
               next_st.cfg_off = wdata;
            end
            REG_SPEED: begin
               next_st.cfg_speed = wdata[15:0];
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         case (addr)
            REG_CTRL:    next_st.rdata = 32'(st.cfg_ctrl);
            REG_TEETH:   next_st.rdata = {st.act_out_t, st.act_in_t};
            REG_AXES:    next_st.rdata = 32'(st.cfg_axes);
            REG_SLIP:    next_st.rdata = st.cfg_slip;
            REG_INPOS:   next_st.rdata = st.cfg_inpos;
            REG_ON_ADDR: next_st.rdata = st.act_on;
            REG_OFFADDR: next_st.rdata = st.act_off;
            REG_SPEED:   next_st.rdata = 32'(st.act_speed);
            REG_STATUS:  next_st.rdata = {28'h0, st.mode_err, st.done, st.engaged, st.virt};
            REG_POS:     next_st.rdata = st.pos;
            default:     next_st.rdata = '0;
         endcase
      end

      // a shorter cycle chosen mid-count wraps at once instead of running round
      if (st.tick_cnt >= lim) begin
         next_st.tick_cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 1'b1;
      end

      if (!st.virt) begin
         next_st.engaged = 1'b0;
         next_st.rate = '0;
         next_st.rem = '0;
         next_st.done = 1'b1;
         if (st.cfg_ctrl[CTRL_VIRT]) begin
            // real to virtual: every setting except the axis count becomes its initial value
            next_st.virt = 1'b1;
            next_st.act_cmd = st.cfg_ctrl[CTRL_CMD];
            next_st.act_mode = (mode_new > MODE_MAX) ? MODE_ONOFF : mode_new;
            next_st.act_on = st.cfg_on;
            next_st.act_off = st.cfg_off;
            next_st.act_speed = st.cfg_speed;
            next_st.act_in_t = st.cfg_in_t;
            next_st.act_out_t = st.cfg_out_t;
            next_st.act_rev = st.cfg_ctrl[CTRL_REV];
            next_st.act_smooth = st.cfg_ctrl[CTRL_SMOOTH];
            next_st.act_meth = st.cfg_ctrl[CTRL_METH +: 2];
            next_st.act_slip = st.cfg_slip;
            next_st.act_inpos = st.cfg_inpos;
         end
      end else begin
         if (!st.cfg_ctrl[CTRL_VIRT]) begin
            next_st.virt = 1'b0;
         end
         if (cv_change) begin
            next_st.act_in_t = st.cfg_in_t;
            next_st.act_out_t = st.cfg_out_t;
         end
         if (st.tick) begin
            next_st.act_cmd = st.cfg_ctrl[CTRL_CMD];
            next_st.act_on = st.cfg_on;
            next_st.act_off = st.cfg_off;
            next_st.act_speed = st.cfg_speed;
            // an illegal mode keeps running on the previous one
            next_st.mode_err = mode_new > MODE_MAX;
            if (mode_new <= MODE_MAX) begin
               next_st.act_mode = mode_new;
            end
            if (st.act_mode == MODE_ADDR) begin
               if (st.act_cmd && st.pos >= $signed(st.act_on)) begin
                  eng_new = 1'b1;
               end else if (!st.act_cmd && st.pos >= $signed(st.act_off)) begin
                  eng_new = 1'b0;
               end
            end else begin
               eng_new = st.act_cmd;
            end
            next_st.rem = rem_full[16:0];
            next_st.g = g_new;
            target = eng_new ? g_new : 32'sh0;
            diff = target - st.rate;
            lin_max = $signed({1'b0, st.act_slip[31:1]} >>> LIN_SHIFT) | 32'sh1;
            case (st.act_meth)
               METH_EXP: begin
                  step = diff >>> EXP_SHIFT;
               end
               METH_LIN: begin
                  if (diff > lin_max) begin
                     step = lin_max;
                  end else if (diff < -lin_max) begin
                     step = -lin_max;
                  end else begin
                     step = diff;
                  end
               end
               default: begin
                  step = diff >>> st.act_slip[3:0];
               end
            endcase
            if (step == '0) begin
               step = diff;
            end
            rate_new = st.act_smooth ? st.rate + step : target;
            left = (target >= rate_new) ? 32'(target - rate_new) : 32'(rate_new - target);
            next_st.rate = rate_new;
            next_st.pos = st.pos + rate_new;
            next_st.engaged = eng_new;
            // a fresh switch beats completion in the same cycle
            if (eng_new != st.engaged && st.act_smooth) begin
               next_st.done = 1'b0;
            end else if (!st.act_smooth || left < st.act_inpos || left == '0) begin
               next_st.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.cfg_in_t <= TEETH_RST;
         st.cfg_out_t <= TEETH_RST;
         st.act_in_t <= TEETH_RST;
         st.act_out_t <= TEETH_RST;
         st.cfg_axes <= AXES_RST;
         st.done <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign op_tick = st.tick;
   assign out_travel = st.rate;
   assign virt_active = st.virt;
   assign clutch_engaged = st.engaged;
   assign smooth_done = st.done;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || !ce);

   sequence s_switch;
      !st.virt && st.cfg_ctrl[CTRL_VIRT];
   endsequence

   a_capture_init: assert property (s_switch ##1 ce |-> st.act_in_t == $past(st.cfg_in_t) && st.virt)
      else $error("teeth not captured at switch");
   a_cycle_resample: assert property (st.virt && st.tick |=> st.act_cmd == $past(st.cfg_ctrl[CTRL_CMD]))
      else $error("clutch command not resampled");
   a_teeth_hold: assert property (st.virt && !cv_change |=> $stable(st.act_out_t))
      else $error("teeth changed without value change");
   a_cycle_len: assert property (st.cfg_axes > AXES_C &&
      st.tick_cnt == CNT_W'(CYC_4 - 1) |=> st.tick)
      else $error("wrong cycle length");
   a_tick_wrap: assert property (st.tick_cnt >= lim |=> st.tick && st.tick_cnt == '0)
      else $error("tick missing");
   a_teeth_range: assert property (st.act_in_t != '0 && st.act_out_t != '0)
      else $error("zero tooth count");
   a_fwd_sign: assert property (st.virt && st.tick && !st.act_rev |=> st.g == $past(quo[31:0]))
      else $error("forward gear output wrong");
   a_rev_sign: assert property (st.virt && st.tick && st.act_rev |=> st.g == -$past(quo[31:0]))
      else $error("reverse gear output wrong");
   a_direct_off: assert property (st.virt && st.tick && !st.act_smooth ##1 !st.engaged |-> out_travel == '0)
      else $error("direct clutch passed pulses while off");
   a_remainder: assert property (st.virt && st.tick |=>
      st.rem < $signed({1'b0, $past(st.act_in_t)}) &&
      -st.rem < $signed({1'b0, $past(st.act_in_t)}))
      else $error("remainder out of range");
   a_done_clear: assert property (st.virt && st.tick && st.act_smooth && eng_new != st.engaged |=> !st.done)
      else $error("done not cleared on switch");
endmodule

// *** tb/drive_axis_model.sv ***
`timescale 1ns/1ns
module drive_axis_model (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               op_tick,
   input  wire logic signed [15:0] cmd_travel,
   input  wire logic               cv_req,
   input  wire logic signed [31:0] out_travel,
   output logic signed [15:0]      in_travel,
   output logic                    cv_change,
   output logic signed [31:0]      out_pos
);
   logic tick_d;
   // ************************************************
   // drive source and output axis
   // ************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_travel <= 16'sh0000;
         cv_change <= 1'b0;
         tick_d    <= 1'b0;
         out_pos   <= 32'sh0000_0000;
      end else begin
         // travel never moves on the sampling edge, so the sample is unambiguous
         if (!op_tick) begin
            in_travel <= cmd_travel;
         end
         cv_change <= cv_req;
         tick_d    <= op_tick;
         // output axis integrates whatever the gear hands it
         if (tick_d) begin
            out_pos <= out_pos + out_travel;
         end
      end
   end
endmodule

// *** tb/gear_clutch_transmission_tb.sv ***
`timescale 1ns/1ns
module gear_clutch_transmission_tb;
   import gear_clutch_pkg::*;
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   logic               ce = 1'b1;
   logic        [7:0]  addr = 8'h00;
   logic        [31:0] wdata = 32'h0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic        [31:0] rdata;
   logic signed [15:0] cmd_travel = 16'sh0;
   logic               cv_req = 1'b0;
   logic signed [15:0] in_travel;
   logic               cv_change;
   logic               op_tick;
   logic signed [31:0] out_travel;
   logic signed [31:0] out_pos;
   logic               virt_active;
   logic               clutch_engaged;
   logic               smooth_done;
   logic        [31:0] rv;
   logic signed [15:0] smp;
   int                 err_total = 0;
   int                 num_checks = 0;
   int                 cycles = 0;
   int                 span;
   int                 rem = 0;
   int                 t_in = 1;
   int                 t_out = 1;
   bit                 rev = 1'b0;
   bit                 low_seen;
   bit                 shaped;
   int                 axes_tbl [8] = '{1, 5, 6, 14, 15, 28, 29, 32};
   int                 per_tbl [8] = '{8, 8, 12, 12, 16, 16, 20, 20};

   gear_clutch_transmission #(.IN_W(16), .CYC_1(8), .CYC_2(12), .CYC_3(16), .CYC_4(20))
      gear_clutch_transmission_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_travel(in_travel),
      .cv_change(cv_change), .op_tick(op_tick), .out_travel(out_travel),
      .virt_active(virt_active), .clutch_engaged(clutch_engaged), .smooth_done(smooth_done));

   drive_axis_model drive_axis_model_i (.ref_clk(ref_clk), .rst(rst), .op_tick(op_tick),
      .cmd_travel(cmd_travel), .cv_req(cv_req), .out_travel(out_travel),
      .in_travel(in_travel), .cv_change(cv_change), .out_pos(out_pos));

   always #2 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         final_report();
      end
   end

   // ************************************************
   // helpers
   // ************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      check(d, exp);
   endtask

   // edge count from the call up to the tick lands in span
   task automatic wait_tick();
      span = 0;
      do begin
         @(posedge ref_clk);
         span++;
      end while (op_tick !== 1'b1 && span < 200);
      // a missing tick would stall every later check, so it ends the run
      if (op_tick !== 1'b1) begin
         err_total++;
         final_report();
      end
      smp = in_travel;
      @(negedge ref_clk);
   endtask

   task automatic pulse_cv();
      @(posedge ref_clk);
      cv_req <= 1'b1;
      @(posedge ref_clk);
      cv_req <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   function automatic logic [31:0] scale(input int x);
      int n;
      int q;
      n = rem + x * t_out;
      q = n / t_in;
      rem = n - q * t_in;
      return 32'(rev ? -q : q);
   endfunction

   // settle picks the last sample so that the carried remainder ends at zero
   task automatic run_ticks(input int n, input bit on, input bit settle);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         cmd_travel <= (settle && i == n - 1) ? 16'(rem) : $signed(12'($urandom));
         wait_tick();
         check(out_travel, on ? scale(int'(smp)) : 32'h0);
      end
      @(posedge ref_clk);
      cmd_travel <= 16'sh0;
   endtask

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      void'($urandom(32'h767020c0));
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check(out_travel, 32'h0);
      check({29'h0, virt_active, clutch_engaged, smooth_done}, 32'h1);
      rd_chk(REG_TEETH, 32'h00010001);
      rd_chk(REG_STATUS, 32'h00000004);
      rd_chk(8'h30, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         bus_wr(REG_AXES, 32'(axes_tbl[i]));
         wait_tick();
         wait_tick();
         wait_tick();
         check(32'(span), 32'(per_tbl[i]));
      end
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (40) begin
         @(negedge ref_clk);
         check(32'(op_tick), 32'h0);
      end
      @(posedge ref_clk);
      ce <= 1'b1;
      bus_wr(REG_AXES, 32'h1);
      $display("test cycle done");
      bus_wr(REG_TEETH, 32'h00020001);
      bus_wr(REG_CTRL, 32'h00000005);
      repeat (3) @(negedge ref_clk);
      check(32'(virt_active), 32'h1);
      rd_chk(REG_TEETH, 32'h00020001);
      t_out = 2;
      bus_wr(REG_SPEED, 32'h00001234);
      bus_wr(REG_ON_ADDR, 32'h00000055);
      wait_tick();
      wait_tick();
      rd_chk(REG_SPEED, 32'h00001234);
      rd_chk(REG_ON_ADDR, 32'h00000055);
      run_ticks(6, 1'b1, 1'b0);
      bus_wr(REG_TEETH, 32'h00020003);
      run_ticks(2, 1'b1, 1'b0);
      rd_chk(REG_TEETH, 32'h00020001);
      pulse_cv();
      t_in = 3;
      rd_chk(REG_TEETH, 32'h00020003);
      run_ticks(10, 1'b1, 1'b1);
      bus_wr(REG_TEETH, 32'h00000001);
      pulse_cv();
      t_in = 1;
      rd_chk(REG_TEETH, 32'h00020001);
      $display("test gear done");
      bus_wr(REG_CTRL, 32'h00000001);
      wait_tick();
      wait_tick();
      run_ticks(3, 1'b0, 1'b0);
      check(32'(clutch_engaged), 32'h0);
      bus_wr(REG_CTRL, 32'h00000701);
      wait_tick();
      bus_rd(REG_STATUS, rv);
      check(rv & 32'h0000000b, 32'h00000009);
      bus_wr(REG_CTRL, 32'h00000005);
      wait_tick();
      wait_tick();
      run_ticks(3, 1'b1, 1'b0);
      check(32'(clutch_engaged), 32'h1);
      bus_rd(REG_POS, rv);
      check(rv, out_pos);
      bus_wr(REG_CTRL, 32'h0);
      wait_tick();
      check(32'(virt_active), 32'h0);
      run_ticks(2, 1'b0, 1'b0);
      $display("test clutch done");
      bus_wr(REG_TEETH, 32'h00050001);
      bus_wr(REG_CTRL, 32'h00000007);
      t_out = 5;
      rev = 1'b1;
      wait_tick();
      wait_tick();
      run_ticks(6, 1'b1, 1'b0);
      bus_wr(REG_CTRL, 32'h0);
      rev = 1'b0;
      $display("test reverse done");
      // address mode: an unreachable engage address keeps the clutch open
      bus_wr(REG_ON_ADDR, 32'h7fffffff);
      bus_wr(REG_CTRL, 32'h00000105);
      repeat (3) wait_tick();
      check(32'(clutch_engaged), 32'h0);
      bus_wr(REG_ON_ADDR, 32'h80000000);
      repeat (3) wait_tick();
      check(32'(clutch_engaged), 32'h1);
      bus_wr(REG_CTRL, 32'h0);
      $display("test address done");
      // lin step comes out near 33 and tc shift 2, so every method settles well inside the bound
      bus_wr(REG_SLIP, 32'h00000402);
      bus_wr(REG_INPOS, 32'h00000001);
      for (int m = 0; m < 3; m++) begin
         wait_tick();
         @(posedge ref_clk);
         cmd_travel <= 16'sd40;
         bus_wr(REG_CTRL, 32'h0000000d | 32'(m << 4));
         low_seen = 1'b0;
         shaped = 1'b0;
         for (int k = 0; k < 80 && !(low_seen && smooth_done === 1'b1); k++) begin
            wait_tick();
            if (smooth_done === 1'b0) low_seen = 1'b1;
            if (out_travel !== 32'sd200) shaped = 1'b1;
         end
         wait_tick();
         check(32'(low_seen), 32'h1);
         check(32'(shaped), 32'h1);
         check(out_travel, 32'd200);
         bus_wr(REG_CTRL, 32'h0);
         cmd_travel <= 16'sh0;
         wait_tick();
         wait_tick();
      end
      $display("test smoothing done");
      final_report();
   end
endmodule
